// ==== verilog/adc_computation_registers.sv ====
// computation result registers of the converter with an APB slave port
//
// Function
// - filter modes check limits when tally reaches target
// - eight-bit tally counts triggers before check
// - filter output is sum shifted right
// - lowpass mode shows lowpass output instead
// - prior source one captures filter at start
// - prior source zero captures result at start
// - prior result keeps result justification format
// - sum is 18-bit signed, sign extended
// - sum writes ignored while conversion runs
// - deviation uses selected formula, against setpoint or prior sample
// - deviation compared with limits sets flags
// - limit interrupt raised per selected condition
// - setpoint is signed sixteen bit
// - limits compared as signed sixteen bit
// - multibyte registers accessed byte by byte
// - result register holds sample, software writable
`timescale 1ns/1ps
module adc_computation_registers (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// converter side
	input  wire logic        convBusy,
	input  wire logic        convStart,
	input  wire logic        sampleValid,
	input  wire logic [9:0]  sampleData,
	// status outputs
	output logic             belowLimitFlag,
	output logic             aboveLimitFlag,
	output logic             irq
);
	// stored registers
	logic [15:0] lowerLimitValue;     // lower limit
	logic [15:0] upperLimitValue;     // upper limit
	logic [15:0] deviationValue;      // setpoint deviation, read only
	logic [15:0] setpointValue;       // setpoint
	logic [15:0] filterOutputValue;   // filter output, read only
	logic [17:0] sumValue;            // accumulator
	logic [7:0]  triggerTally;        // trigger count
	logic [7:0]  repeatTarget;        // count that triggers the check
	logic [15:0] priorSample;         // prior sample, read only
	logic [15:0] sampleOutcomeValue;  // conversion result
	logic [7:0]  configReg;           // mode, prior source, formula
	logic [7:0]  config2Reg;          // shift, interrupt mode, format
	logic [1:0]  irqStatus;           // sticky events
	logic [1:0]  irqMask;             // event enables

	// next values
	logic [15:0] next_lowerLimitValue;
	logic [15:0] next_upperLimitValue;
	logic [15:0] next_deviationValue;
	logic [15:0] next_setpointValue;
	logic [15:0] next_filterOutputValue;
	logic [17:0] next_sumValue;
	logic [7:0]  next_triggerTally;
	logic [7:0]  next_repeatTarget;
	logic [15:0] next_priorSample;
	logic [15:0] next_sampleOutcomeValue;
	logic [7:0]  next_configReg;
	logic [7:0]  next_config2Reg;
	logic [1:0]  next_irqStatus;
	logic [1:0]  next_irqMask;
	logic        next_belowLimitFlag;
	logic        next_aboveLimitFlag;
	logic        next_irq;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	// decoded fields
	logic [2:0]  modeSel;             // computation mode
	logic        priorSourceSelect;   // prior sample source
	logic [2:0]  deviationFormula;    // deviation formula
	logic [2:0]  shiftAmount;         // right shift of the sum
	logic [2:0]  limitInterruptMode;  // interrupt condition
	logic        justifyFormat;       // one: right justified

	// bus decode
	logic        access;              // access phase, first cycle
	logic        wrByte;              // write of the low byte lane
	logic [13:0] regIdx;              // register index from address
	logic        aligned;             // address on a word boundary
	logic        mapped;              // index hits a register

	// datapath
	logic [15:0] sampleWord;          // justified sample
	logic [17:0] sumNew;              // sum after the sample
	logic [15:0] filterNew;           // filter after the sample
	logic [7:0]  tallyInc;            // tally after the trigger
	logic        filterMode;          // mode uses the target count
	logic        checkNow;            // limit check this sample
	logic signed [16:0] devWide;      // deviation with guard bit
	logic [15:0] devNew;              // deviation result
	logic        belowNew;            // deviation under lower limit
	logic        aboveNew;            // deviation over upper limit
	logic        threshEvent;         // limit interrupt condition met

	assign modeSel            = configReg[adc_comp_pkg::CFG_MODE_LSB +: 3];
	assign priorSourceSelect  = configReg[adc_comp_pkg::CFG_PRIOR_SOURCE_SELECT_BIT];
	assign deviationFormula   = configReg[adc_comp_pkg::CFG_DEVIATION_FORMULA_SELECT_LSB +: 3];
	assign shiftAmount        = config2Reg[adc_comp_pkg::CFG2_SHIFT_LSB +: 3];
	assign limitInterruptMode = config2Reg[adc_comp_pkg::CFG2_TMD_LSB +: 3];
	assign justifyFormat      = config2Reg[adc_comp_pkg::CFG2_FMT_BIT];

	// one wait state: pready rises in the second access cycle
	assign access  = psel & penable & ~pready;
	assign regIdx  = paddr[15:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign wrByte  = access & pwrite & pstrb[0] & aligned;

	// sample justified as the format bit asks
	assign sampleWord = justifyFormat ? {6'h00, sampleData} : {sampleData, 6'h00};

	// shared accumulate and filter arithmetic
	adc_compute_unit u_compute (
		.mode        (modeSel),
		.shiftAmount (shiftAmount),
		.sumCur      (sumValue),
		.sampleWord  (sampleWord),
		.sumNew      (sumNew),
		.filterNew   (filterNew)
	);

	// tally, check moment, deviation and limit comparison for a new sample
	always_comb begin
		filterMode = (modeSel == adc_comp_pkg::MODE_AVERAGE) |
			(modeSel == adc_comp_pkg::MODE_BURST) |
			(modeSel == adc_comp_pkg::MODE_LOWPASS);
		// saturate so a long run cannot wrap past the target
		tallyInc = (triggerTally == 8'hFF) ? 8'hFF : 8'(triggerTally + 8'h01);
		// filter modes wait for the target, others check every sample
		checkNow = filterMode ? (tallyInc == repeatTarget) : 1'b1;
		unique case (deviationFormula)
			adc_comp_pkg::DEVIATION_FORMULA_SELECT_RES_SETPT: begin
				devWide = 17'(signed'(sampleWord)) - 17'(signed'(setpointValue));
			end
			adc_comp_pkg::DEVIATION_FORMULA_SELECT_FILT_SETPT: begin
				devWide = 17'(signed'(filterNew)) - 17'(signed'(setpointValue));
			end
			adc_comp_pkg::DEVIATION_FORMULA_SELECT_FILT_PRIOR: begin
				devWide = 17'(signed'(filterNew)) - 17'(signed'(priorSample));
			end
			default: begin
				// undefined codes fall back to result minus prior
				devWide = 17'(signed'(sampleWord)) - 17'(signed'(priorSample));
			end
		endcase
		devNew   = devWide[15:0];
		belowNew = $signed(devNew) < $signed(lowerLimitValue);
		aboveNew = $signed(devNew) > $signed(upperLimitValue);
		unique case (limitInterruptMode)
			adc_comp_pkg::TMD_BELOW:   threshEvent = belowNew;
			adc_comp_pkg::TMD_ABOVE:   threshEvent = aboveNew;
			adc_comp_pkg::TMD_INSIDE:  threshEvent = ~belowNew & ~aboveNew;
			adc_comp_pkg::TMD_OUTSIDE: threshEvent = belowNew | aboveNew;
			adc_comp_pkg::TMD_ALWAYS:  threshEvent = 1'b1;
			default:                   threshEvent = 1'b0; // never
		endcase
	end

	// register file: software writes first, hardware updates override them
	always_comb begin
		next_lowerLimitValue    = lowerLimitValue;
		next_upperLimitValue    = upperLimitValue;
		next_deviationValue     = deviationValue;
		next_setpointValue      = setpointValue;
		next_filterOutputValue  = filterOutputValue;
		next_sumValue           = sumValue;
		next_triggerTally       = triggerTally;
		next_repeatTarget       = repeatTarget;
		next_priorSample        = priorSample;
		next_sampleOutcomeValue = sampleOutcomeValue;
		next_configReg          = configReg;
		next_config2Reg         = config2Reg;
		next_irqStatus          = irqStatus;
		next_irqMask            = irqMask;
		next_belowLimitFlag     = belowLimitFlag;
		next_aboveLimitFlag     = aboveLimitFlag;
		// byte-wide software writes, one byte per index
		if (wrByte) begin
			unique case (regIdx)
				adc_comp_pkg::IDX_LOWER_LO:   next_lowerLimitValue[7:0]  = pwdata[7:0];
				adc_comp_pkg::IDX_LOWER_HI:   next_lowerLimitValue[15:8] = pwdata[7:0];
				adc_comp_pkg::IDX_UPPER_LO:   next_upperLimitValue[7:0]  = pwdata[7:0];
				adc_comp_pkg::IDX_UPPER_HI:   next_upperLimitValue[15:8] = pwdata[7:0];
				adc_comp_pkg::IDX_SETPT_LO:   next_setpointValue[7:0]    = pwdata[7:0];
				adc_comp_pkg::IDX_SETPT_HI:   next_setpointValue[15:8]   = pwdata[7:0];
				adc_comp_pkg::IDX_SUM_LO: begin
					if (!convBusy) next_sumValue[7:0] = pwdata[7:0];
				end
				adc_comp_pkg::IDX_SUM_HI: begin
					if (!convBusy) next_sumValue[15:8] = pwdata[7:0];
				end
				adc_comp_pkg::IDX_SUM_UP: begin
					// only the two live bits are stored; the rest mirror the sign
					if (!convBusy) next_sumValue[17:16] = pwdata[1:0];
				end
				adc_comp_pkg::IDX_TALLY:      next_triggerTally          = pwdata[7:0];
				adc_comp_pkg::IDX_TARGET:     next_repeatTarget          = pwdata[7:0];
				adc_comp_pkg::IDX_OUTCOME_LO: next_sampleOutcomeValue[7:0]  = pwdata[7:0];
				adc_comp_pkg::IDX_OUTCOME_HI: next_sampleOutcomeValue[15:8] = pwdata[7:0];
				adc_comp_pkg::IDX_CONFIG:     next_configReg             = pwdata[7:0];
				adc_comp_pkg::IDX_CONFIG2:    next_config2Reg            = pwdata[7:0];
				adc_comp_pkg::IDX_IRQ_STATUS: next_irqStatus = irqStatus & ~pwdata[1:0];
				adc_comp_pkg::IDX_IRQ_MASK:   next_irqMask               = pwdata[1:0];
				default: begin
					// deviation, filter, prior and flags keep their value
					next_irqMask = next_irqMask;
				end
			endcase
		end
		// start of conversion latches the prior sample
		if (convStart) begin
			if (priorSourceSelect) begin
				next_priorSample = filterOutputValue;
			end else begin
				// result already carries its justification, so copy as is
				next_priorSample = sampleOutcomeValue;
			end
		end
		// a finished sample updates result, sum, filter and the check
		if (sampleValid) begin
			next_sampleOutcomeValue = sampleWord;
			next_filterOutputValue  = filterNew;
			next_sumValue           = sumNew;
			next_irqStatus[adc_comp_pkg::IRQ_DONE_BIT] = 1'b1;
			if (modeSel != adc_comp_pkg::MODE_BASIC) begin
				next_triggerTally = tallyInc;
			end
			if (checkNow) begin
				next_deviationValue = devNew;
				next_belowLimitFlag = belowNew;
				next_aboveLimitFlag = aboveNew;
				if (threshEvent) begin
					// set beats a same-cycle clear
					next_irqStatus[adc_comp_pkg::IRQ_THRESH_BIT] = 1'b1;
				end
				if (filterMode) begin
					next_triggerTally = adc_comp_pkg::RST_BYTE;
				end
				// averages restart; the lowpass sum must keep its history
				if ((modeSel == adc_comp_pkg::MODE_AVERAGE) |
					(modeSel == adc_comp_pkg::MODE_BURST)) begin
					next_sumValue = adc_comp_pkg::RST_SUM;
				end
			end
		end
		// interrupt level from the updated state
		next_irq = |(next_irqStatus & next_irqMask);
	end

	// read mux and bus answer
	always_comb begin
		next_prdata  = 32'h00000000;
		next_pready  = access;
		next_pslverr = 1'b0;
		mapped       = 1'b1;
		unique case (regIdx)
			adc_comp_pkg::IDX_LOWER_LO:   next_prdata[7:0] = lowerLimitValue[7:0];
			adc_comp_pkg::IDX_LOWER_HI:   next_prdata[7:0] = lowerLimitValue[15:8];
			adc_comp_pkg::IDX_UPPER_LO:   next_prdata[7:0] = upperLimitValue[7:0];
			adc_comp_pkg::IDX_UPPER_HI:   next_prdata[7:0] = upperLimitValue[15:8];
			adc_comp_pkg::IDX_DEV_LO:     next_prdata[7:0] = deviationValue[7:0];
			adc_comp_pkg::IDX_DEV_HI:     next_prdata[7:0] = deviationValue[15:8];
			adc_comp_pkg::IDX_SETPT_LO:   next_prdata[7:0] = setpointValue[7:0];
			adc_comp_pkg::IDX_SETPT_HI:   next_prdata[7:0] = setpointValue[15:8];
			adc_comp_pkg::IDX_FILTER_LO:  next_prdata[7:0] = filterOutputValue[7:0];
			adc_comp_pkg::IDX_FILTER_HI:  next_prdata[7:0] = filterOutputValue[15:8];
			adc_comp_pkg::IDX_SUM_LO:     next_prdata[7:0] = sumValue[7:0];
			adc_comp_pkg::IDX_SUM_HI:     next_prdata[7:0] = sumValue[15:8];
			adc_comp_pkg::IDX_SUM_UP:     next_prdata[7:0] = {{6{sumValue[17]}}, sumValue[17:16]};
			adc_comp_pkg::IDX_TALLY:      next_prdata[7:0] = triggerTally;
			adc_comp_pkg::IDX_TARGET:     next_prdata[7:0] = repeatTarget;
			adc_comp_pkg::IDX_PRIOR_LO:   next_prdata[7:0] = priorSample[7:0];
			adc_comp_pkg::IDX_PRIOR_HI:   next_prdata[7:0] = priorSample[15:8];
			adc_comp_pkg::IDX_OUTCOME_LO: next_prdata[7:0] = sampleOutcomeValue[7:0];
			adc_comp_pkg::IDX_OUTCOME_HI: next_prdata[7:0] = sampleOutcomeValue[15:8];
			adc_comp_pkg::IDX_CONFIG:     next_prdata[7:0] = configReg;
			adc_comp_pkg::IDX_CONFIG2:    next_prdata[7:0] = config2Reg;
			adc_comp_pkg::IDX_IRQ_STATUS: next_prdata[1:0] = irqStatus;
			adc_comp_pkg::IDX_IRQ_MASK:   next_prdata[1:0] = irqMask;
			adc_comp_pkg::IDX_FLAGS:      next_prdata[1:0] = {aboveLimitFlag, belowLimitFlag};
			default:                      mapped = 1'b0;
		endcase
		// unmapped or misaligned: error, read data zero, nothing written
		if (!(mapped & aligned)) begin
			next_prdata  = 32'h00000000;
			next_pslverr = access;
		end
		if (!access | pwrite) begin
			next_prdata = 32'h00000000;
		end
	end

	// register every state and output
	always_ff @(posedge clk) begin
		if (rst) begin
			lowerLimitValue    <= adc_comp_pkg::RST_WORD;
			upperLimitValue    <= adc_comp_pkg::RST_WORD;
			deviationValue     <= adc_comp_pkg::RST_WORD;
			setpointValue      <= adc_comp_pkg::RST_WORD;
			filterOutputValue  <= adc_comp_pkg::RST_WORD;
			sumValue           <= adc_comp_pkg::RST_SUM;
			triggerTally       <= adc_comp_pkg::RST_BYTE;
			repeatTarget       <= adc_comp_pkg::RST_TARGET;
			priorSample        <= adc_comp_pkg::RST_WORD;
			sampleOutcomeValue <= adc_comp_pkg::RST_WORD;
			configReg          <= adc_comp_pkg::RST_BYTE;
			config2Reg         <= adc_comp_pkg::RST_BYTE;
			irqStatus          <= adc_comp_pkg::RST_IRQ;
			irqMask            <= adc_comp_pkg::RST_IRQ;
			belowLimitFlag     <= 1'b0;
			aboveLimitFlag     <= 1'b0;
			irq                <= 1'b0;
			prdata             <= 32'h00000000;
			pready             <= 1'b0;
			pslverr            <= 1'b0;
		end else begin
			lowerLimitValue    <= next_lowerLimitValue;
			upperLimitValue    <= next_upperLimitValue;
			deviationValue     <= next_deviationValue;
			setpointValue      <= next_setpointValue;
			filterOutputValue  <= next_filterOutputValue;
			sumValue           <= next_sumValue;
			triggerTally       <= next_triggerTally;
			repeatTarget       <= next_repeatTarget;
			priorSample        <= next_priorSample;
			sampleOutcomeValue <= next_sampleOutcomeValue;
			configReg          <= next_configReg;
			config2Reg         <= next_config2Reg;
			irqStatus          <= next_irqStatus;
			irqMask            <= next_irqMask;
			belowLimitFlag     <= next_belowLimitFlag;
			aboveLimitFlag     <= next_aboveLimitFlag;
			irq                <= next_irq;
			prdata             <= next_prdata;
			pready             <= next_pready;
			pslverr            <= next_pslverr;
		end
	end

endmodule : adc_computation_registers

// ==== common/adc_comp_pkg.sv ====
// constants and types for the converter computation register set
package adc_comp_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [13:0] IDX_LOWER_LO    = 14'h1D0C;
	localparam logic [13:0] IDX_LOWER_HI    = 14'h1D0D;
	localparam logic [13:0] IDX_UPPER_LO    = 14'h1D0E;
	localparam logic [13:0] IDX_UPPER_HI    = 14'h1D0F;
	localparam logic [13:0] IDX_DEV_LO      = 14'h1D10;
	localparam logic [13:0] IDX_DEV_HI      = 14'h1D11;
	localparam logic [13:0] IDX_SETPT_LO    = 14'h1D12;
	localparam logic [13:0] IDX_SETPT_HI    = 14'h1D13;
	localparam logic [13:0] IDX_FILTER_LO   = 14'h1D14;
	localparam logic [13:0] IDX_FILTER_HI   = 14'h1D15;
	localparam logic [13:0] IDX_SUM_LO      = 14'h1D16;
	localparam logic [13:0] IDX_SUM_HI      = 14'h1D17;
	localparam logic [13:0] IDX_SUM_UP      = 14'h1D18;
	localparam logic [13:0] IDX_TALLY       = 14'h1D19;
	localparam logic [13:0] IDX_TARGET      = 14'h1D1A;
	localparam logic [13:0] IDX_PRIOR_LO    = 14'h1D1B;
	localparam logic [13:0] IDX_PRIOR_HI    = 14'h1D1C;
	localparam logic [13:0] IDX_OUTCOME_LO  = 14'h1D1D;
	localparam logic [13:0] IDX_OUTCOME_HI  = 14'h1D1E;
	localparam logic [13:0] IDX_CONFIG      = 14'h1D40;
	localparam logic [13:0] IDX_CONFIG2     = 14'h1D41;
	localparam logic [13:0] IDX_IRQ_STATUS  = 14'h1D42;
	localparam logic [13:0] IDX_IRQ_MASK    = 14'h1D43;
	localparam logic [13:0] IDX_FLAGS       = 14'h1D44;

	// field positions in the configuration registers
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_PRIOR_SOURCE_SELECT_BIT   = 3;
	localparam int CFG_DEVIATION_FORMULA_SELECT_LSB   = 4;
	localparam int CFG2_SHIFT_LSB = 0;
	localparam int CFG2_TMD_LSB   = 3;
	localparam int CFG2_FMT_BIT   = 6;

	// status, mask and flag bits
	localparam int IRQ_THRESH_BIT = 0;
	localparam int IRQ_DONE_BIT   = 1;
	localparam int FLAG_BELOW_BIT = 0;
	localparam int FLAG_ABOVE_BIT = 1;

	// values after reset
	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [17:0] RST_SUM    = 18'h00000;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [7:0]  RST_TARGET = 8'h00;
	localparam logic [1:0]  RST_IRQ    = 2'h0;

	// computation modes
	typedef enum logic [2:0] {
		MODE_BASIC   = 3'b000,
		MODE_ACCUM   = 3'b001,
		MODE_AVERAGE = 3'b010,
		MODE_BURST   = 3'b011,
		MODE_LOWPASS = 3'b100
	} mode_t;

	// deviation formulas
	typedef enum logic [2:0] {
		DEVIATION_FORMULA_SELECT_RES_PRIOR    = 3'b000,
		DEVIATION_FORMULA_SELECT_RES_SETPT    = 3'b001,
		DEVIATION_FORMULA_SELECT_FILT_SETPT   = 3'b010,
		DEVIATION_FORMULA_SELECT_FILT_PRIOR   = 3'b011
	} deviation_formula_select_t;

	// limit interrupt conditions
	typedef enum logic [2:0] {
		TMD_NEVER   = 3'b000,
		TMD_BELOW   = 3'b001,
		TMD_ABOVE   = 3'b010,
		TMD_INSIDE  = 3'b011,
		TMD_OUTSIDE = 3'b100,
		TMD_ALWAYS  = 3'b101
	} tmd_t;

endpackage : adc_comp_pkg

// ==== verilog/adc_compute_unit.sv ====
// accumulator and filter arithmetic for one new sample
`timescale 1ns/1ps
module adc_compute_unit (
	// operating selection
	input  wire logic [2:0]  mode,
	input  wire logic [2:0]  shiftAmount,
	// operands
	input  wire logic [17:0] sumCur,
	input  wire logic [15:0] sampleWord,
	// results
	output logic      [17:0] sumNew,
	output logic      [15:0] filterNew
);
	logic signed [18:0] sumWide;   // one guard bit for the add
	logic signed [17:0] sumShift;  // current sum shifted for the decay term
	logic signed [17:0] newShift;  // new sum shifted for the filter value

	// sum update and filter value; the sum wraps at 18 bits by design
	always_comb begin
		sumShift = $signed(sumCur) >>> shiftAmount;
		sumWide  = 19'(signed'(sumCur)) + 19'(signed'(sampleWord));
		unique case (mode)
			adc_comp_pkg::MODE_LOWPASS: begin
				// decay by the shifted sum, then add the sample
				sumWide = sumWide - 19'(sumShift);
			end
			adc_comp_pkg::MODE_ACCUM,
			adc_comp_pkg::MODE_AVERAGE,
			adc_comp_pkg::MODE_BURST: begin
				sumWide = sumWide;
			end
			default: begin
				// basic mode leaves the sum alone
				sumWide = 19'(signed'(sumCur));
			end
		endcase
		sumNew    = sumWide[17:0];
		newShift  = $signed(sumNew) >>> shiftAmount;
		filterNew = newShift[15:0];
	end

endmodule : adc_compute_unit

// ==== test/adc_comp_checker.sv ====
// port assertions for the computation register set
`timescale 1ns/1ps
module adc_comp_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// apb slave port
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// converter and status
	input wire logic        sampleValid,
	input wire logic        belowLimitFlag,
	input wire logic        aboveLimitFlag
);
	// single clock domain, so one default clock and reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// access phase is exactly two cycles long
	a_ready_after_take: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_no_idle_ready: assert property (!psel |=> !pready)
		else $error("pready without access");
	a_misaligned_error: assert property (psel && penable && !pready && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside access end");
	a_byte_wide_read: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data wider than a byte");
	a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h00000000)
		else $error("read data on a write");
	a_flags_hold: assert property (!sampleValid |=> $stable({belowLimitFlag, aboveLimitFlag}))
		else $error("flags moved without a check");
endmodule : adc_comp_checker

bind adc_computation_registers adc_comp_checker chk (.clk, .rst, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .sampleValid, .belowLimitFlag, .aboveLimitFlag);

// ==== test/tb_top.sv ====
// self-checking bench for the computation register set
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	// bench-driven inputs and captured answers
	logic        clk, rst, psel, penable, pwrite, convBusy, convStart, sampleValid, errv;
	logic [15:0] paddr;
	logic [31:0] pwdata, rdv, prdata;
	logic [3:0]  pstrb;
	logic [9:0]  sampleData;
	logic        pready, pslverr, belowLimitFlag, aboveLimitFlag, irq;
	int          errTotal, testsRun;
	// places read back as zero after reset, and read-only places
	logic [13:0] zeroIdx [7] = '{adc_comp_pkg::IDX_LOWER_LO, adc_comp_pkg::IDX_UPPER_HI,
		adc_comp_pkg::IDX_SETPT_LO, adc_comp_pkg::IDX_TALLY, adc_comp_pkg::IDX_PRIOR_HI,
		adc_comp_pkg::IDX_OUTCOME_LO, adc_comp_pkg::IDX_SUM_UP};
	logic [13:0] roIdx [3] = '{adc_comp_pkg::IDX_FILTER_LO, adc_comp_pkg::IDX_DEV_HI,
		adc_comp_pkg::IDX_PRIOR_LO};

	adc_computation_registers dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .convBusy, .convStart, .sampleValid, .sampleData,
		.belowLimitFlag, .aboveLimitFlag, .irq);

	// 50 ns period
	always #25 clk = ~clk;

	// one transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [13:0] idx, input logic [1:0] lo,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, lo};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		// pready is read at the rising edge, before that edge updates it
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a missing answer counts as a mismatch
		if (pready !== 1'b1) errTotal++;
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		apb(1'b1, idx, 2'h0, d);
	endtask : wr

	task automatic rd(input logic [13:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 2'h0, 8'h00);
		`CHK(rdv, {24'h000000, e})
	endtask : rd

	// sample-done or conversion-start pulse; returns once irq has settled
	task automatic pulse(input logic s, input logic [9:0] d);
		@(posedge clk);
		sampleValid <= s;
		convStart <= !s;
		sampleData <= d;
		@(posedge clk);
		sampleValid <= 1'b0;
		convStart <= 1'b0;
		repeat (2) @(negedge clk);
	endtask : pulse

	task automatic reportAndStop;
		$display("compares %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : reportAndStop

	// watchdog far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		errTotal++;
		reportAndStop();
	end

	initial begin
		{clk, psel, penable, pwrite, convBusy, convStart, sampleValid, paddr, pwdata} = '0;
		{rst, pstrb, sampleData, errTotal, testsRun} = {1'b1, 4'hF, 10'h000, 64'h0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rd(zeroIdx[i], 8'h00);
		apb(1'b0, 14'h1D20, 2'h0, 8'h00);
		`CHK(errv, 1'b1)
		apb(1'b1, adc_comp_pkg::IDX_LOWER_LO, 2'h2, 8'h55);
		`CHK(errv, 1'b1)
		rd(adc_comp_pkg::IDX_LOWER_LO, 8'h00);
		// a write with the low byte lane off must not land
		pstrb <= 4'h0;
		wr(adc_comp_pkg::IDX_LOWER_HI, 8'h33);
		pstrb <= 4'hF;
		rd(adc_comp_pkg::IDX_LOWER_HI, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(roIdx[i], 8'hA5);
			rd(roIdx[i], 8'h00);
		end
		wr(adc_comp_pkg::IDX_UPPER_LO, 8'h10);
		wr(adc_comp_pkg::IDX_SETPT_HI, 8'h02);
		rd(adc_comp_pkg::IDX_UPPER_LO, 8'h10);
		rd(adc_comp_pkg::IDX_SETPT_HI, 8'h02);
		// basic mode, right justified: deviation 0x0100 - 0x0200 is negative
		wr(adc_comp_pkg::IDX_CONFIG, {1'b0, adc_comp_pkg::DEVIATION_FORMULA_SELECT_RES_SETPT, 1'b0, 3'h0});
		wr(adc_comp_pkg::IDX_CONFIG2, {2'b01, adc_comp_pkg::TMD_BELOW, 3'h0});
		wr(adc_comp_pkg::IDX_IRQ_MASK, 8'h01);
		pulse(1'b1, 10'h100);
		`CHK(irq, 1'b1)
		`CHK({belowLimitFlag, aboveLimitFlag}, 2'b10)
		rd(adc_comp_pkg::IDX_DEV_HI, 8'hFF);
		rd(adc_comp_pkg::IDX_OUTCOME_HI, 8'h01);
		wr(adc_comp_pkg::IDX_IRQ_STATUS, 8'h03);
		@(negedge clk);
		`CHK(irq, 1'b0)
		pulse(1'b0, 10'h000);
		rd(adc_comp_pkg::IDX_PRIOR_HI, 8'h01);
		// left justified sample, limit interrupt off
		wr(adc_comp_pkg::IDX_CONFIG2, {2'b00, adc_comp_pkg::TMD_NEVER, 3'h0});
		pulse(1'b1, 10'h3FF);
		rd(adc_comp_pkg::IDX_OUTCOME_LO, 8'hC0);
		pulse(1'b0, 10'h000);
		rd(adc_comp_pkg::IDX_PRIOR_LO, 8'hC0);
		// accumulate 6 and 10, shift one, prior taken from the filter
		wr(adc_comp_pkg::IDX_CONFIG, {1'b0, adc_comp_pkg::DEVIATION_FORMULA_SELECT_RES_PRIOR, 1'b1, 3'h1});
		wr(adc_comp_pkg::IDX_CONFIG2, {2'b01, adc_comp_pkg::TMD_NEVER, 3'h1});
		pulse(1'b1, 10'h006);
		pulse(1'b1, 10'h00A);
		rd(adc_comp_pkg::IDX_SUM_LO, 8'h10);
		rd(adc_comp_pkg::IDX_FILTER_LO, 8'h08);
		pulse(1'b0, 10'h000);
		rd(adc_comp_pkg::IDX_PRIOR_LO, 8'h08);
		wr(adc_comp_pkg::IDX_SUM_UP, 8'h02);
		rd(adc_comp_pkg::IDX_SUM_UP, 8'hFE);
		// sum write while busy must be dropped
		convBusy <= 1'b1;
		wr(adc_comp_pkg::IDX_SUM_LO, 8'h77);
		convBusy <= 1'b0;
		rd(adc_comp_pkg::IDX_SUM_LO, 8'h10);
		// average of two: only the second sample reaches the check
		wr(adc_comp_pkg::IDX_CONFIG, {1'b0, adc_comp_pkg::DEVIATION_FORMULA_SELECT_RES_SETPT, 1'b0, 3'h2});
		wr(adc_comp_pkg::IDX_CONFIG2, {2'b01, adc_comp_pkg::TMD_ABOVE, 3'h0});
		wr(adc_comp_pkg::IDX_TARGET, 8'h02);
		// accumulate mode left the tally counting, so start it from zero
		wr(adc_comp_pkg::IDX_TALLY, 8'h00);
		wr(adc_comp_pkg::IDX_IRQ_STATUS, 8'h03);
		pulse(1'b1, 10'h300);
		`CHK(irq, 1'b0)
		rd(adc_comp_pkg::IDX_TALLY, 8'h01);
		pulse(1'b1, 10'h300);
		`CHK(irq, 1'b1)
		rd(adc_comp_pkg::IDX_TALLY, 8'h00);
		// lowpass, shift one: filter 0x80 then 0xC0, checked on the second sample
		wr(adc_comp_pkg::IDX_CONFIG, {1'b0, adc_comp_pkg::DEVIATION_FORMULA_SELECT_FILT_SETPT, 1'b0, 3'h4});
		wr(adc_comp_pkg::IDX_CONFIG2, {2'b01, adc_comp_pkg::TMD_OUTSIDE, 3'h1});
		wr(adc_comp_pkg::IDX_IRQ_STATUS, 8'h03);
		pulse(1'b1, 10'h100);
		`CHK(irq, 1'b0)
		rd(adc_comp_pkg::IDX_FILTER_LO, 8'h80);
		pulse(1'b1, 10'h100);
		`CHK(irq, 1'b1)
		`CHK({belowLimitFlag, aboveLimitFlag}, 2'b10)
		rd(adc_comp_pkg::IDX_FILTER_LO, 8'hC0);
		rd(adc_comp_pkg::IDX_SUM_LO, 8'h80);
		rd(adc_comp_pkg::IDX_TALLY, 8'h00);
		reportAndStop();
	end
endmodule : tb_top
